// *** flash_iap_pkg.sv ***
// constants, offsets, field layouts and states of the flash programming controller
package flash_iap_pkg;

   // ------------------------------------------------------------
   // register placement in the data memory
   // ------------------------------------------------------------
   localparam logic [1:0] REG_SECTOR = 2'h1;
   localparam logic [7:0] OFF_CONTROL_MAIN = 8'h40;
   localparam logic [7:0] OFF_CHIP_RESET = 8'h41;
   localparam logic [7:0] OFF_BUFFER_CLEAR = 8'h42;
   localparam logic [7:0] OFF_ADDRESS_LOW = 8'h43;
   localparam logic [7:0] OFF_ADDRESS_HIGH = 8'h44;
   localparam logic [7:0] OFF_DATA0_LOW = 8'h45;

   // ------------------------------------------------------------
   // field positions of the main control and buffer clear registers
   // ------------------------------------------------------------
   localparam int BIT_ERASE_WRITE_ENABLED = 7;
   localparam int BIT_MODE_LSB = 4;
   localparam int BIT_ENABLE_TRIGGER = 3;
   localparam int BIT_WRITE_START = 2;
   localparam int BIT_READ_ENABLE = 1;
   localparam int BIT_READ_START = 0;
   localparam int BIT_BUFFER_CLEAR = 0;

   // ------------------------------------------------------------
   // modes, reset values, counts and patterns
   // ------------------------------------------------------------
   localparam logic [2:0] MODE_WRITE = 3'h0;
   localparam logic [2:0] MODE_PAGE_ERASE = 3'h1;
   localparam logic [2:0] MODE_READ = 3'h3;
   localparam logic [2:0] MODE_ENABLE = 3'h6;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [13:0] RESET_ADDRESS = 14'h0000;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [7:0] CHIP_RESET_VALUE = 8'h55;
   localparam logic [5:0] PAGE_LAST_WORD = 6'h3F;
   localparam int PAGE_WORDS = 64;
   localparam logic [11:0] ENABLE_WINDOW_CYCLES = 12'h800;
   // unlock patterns: arbitrary values
   localparam logic [15:0] UNLOCK_PATTERN1 = 16'hA5C3;
   localparam logic [15:0] UNLOCK_PATTERN2 = 16'h3C5A;
   localparam logic [15:0] UNLOCK_PATTERN3 = 16'h96E1;

   // ------------------------------------------------------------
   // flash array commands and sequencer states
   // ------------------------------------------------------------
   localparam logic [1:0] CMD_ERASE = 2'h1;
   localparam logic [1:0] CMD_PROGRAM = 2'h2;
   localparam logic [1:0] CMD_READ = 2'h3;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ERASE = 4'h2,
      ST_PROG = 4'h4,
      ST_READ = 4'h8
   } seq_state_e;

endpackage

// *** page_write_buffer.sv ***
// page-sized word buffer held in flip-flops, with a one-cycle whole clear
`timescale 1ns/1ps
module page_write_buffer (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic wr_en,
   input wire logic [5:0] wr_idx,
   input wire logic [15:0] wr_data,
   input wire logic [5:0] rd_idx,
   output logic [15:0] rd_data
);

   logic [15:0] word_reg [0:flash_iap_pkg::PAGE_WORDS-1];

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // clear wins over a load; the sequencer never asks for both at once
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < flash_iap_pkg::PAGE_WORDS; i++) begin
            word_reg[i] <= flash_iap_pkg::RESET_WORD;
         end
      end else if (clear) begin
         for (int i = 0; i < flash_iap_pkg::PAGE_WORDS; i++) begin
            word_reg[i] <= flash_iap_pkg::RESET_WORD;
         end
      end else if (wr_en) begin
         word_reg[wr_idx] <= wr_data;
      end
   end

   assign rd_data = word_reg[rd_idx];

endmodule // page_write_buffer

// *** flash_iap_controller.sv ***
// in-application flash programming controller behind the core's data memory
`timescale 1ns/1ps
module flash_iap_controller (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [9:0] mem_addr,
   input wire logic mem_ext_access,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   output logic cpu_hold,
   output logic chip_reset_req,
   output logic flash_req,
   output logic [1:0] flash_cmd,
   output logic [13:0] flash_addr,
   output logic [15:0] flash_wdata,
   input wire logic flash_ack,
   input wire logic [15:0] flash_rdata
);

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [9:0] a, input logic ext, input logic [7:0] off);
      hit = ext && (a[9:8] == flash_iap_pkg::REG_SECTOR) && (a[7:0] == off);
   endfunction

   function automatic logic [7:0] data_off(input int n, input logic high);
      data_off = flash_iap_pkg::OFF_DATA0_LOW + 8'(2 * n) + {7'h00, high};
   endfunction

   flash_iap_pkg::seq_state_e state_reg;
   logic ew_enabled_reg;
   logic [2:0] mode_reg;
   logic trigger_reg;
   logic write_start_reg;
   logic read_enable_reg;
   logic read_start_reg;
   logic buffer_clear_reg;
   logic [7:0] reset_pattern_reg;
   logic [13:0] addr_reg;
   logic [7:0] data_lo_reg [0:3];
   logic [7:0] data_hi_reg [0:3];
   logic [11:0] timer_reg;
   logic [5:0] word_idx_reg;
   logic [15:0] buf_word;
   logic wr_main;
   logic wr_high0;
   logic buf_load;
   logic buf_clear;
   logic write_done;
   logic read_done;
   logic prog_last;
   logic unlock_ok;
   logic timeout;

   assign wr_main = mem_wr && hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_CONTROL_MAIN);
   assign wr_high0 = mem_wr && hit(mem_addr, mem_ext_access, data_off(0, 1'b1));
   // loads are ignored while a process runs; the core is stalled then anyway
   assign buf_load = wr_high0 && ew_enabled_reg && (state_reg == flash_iap_pkg::ST_IDLE);
   assign prog_last = (state_reg == flash_iap_pkg::ST_PROG) && flash_ack
                      && (word_idx_reg == flash_iap_pkg::PAGE_LAST_WORD);
   assign buf_clear = buffer_clear_reg || prog_last;
   assign timeout = trigger_reg && (timer_reg == flash_iap_pkg::ENABLE_WINDOW_CYCLES);
   // compared as the last pattern word lands, so stale patterns never unlock
   assign unlock_ok = trigger_reg && (mode_reg == flash_iap_pkg::MODE_ENABLE)
      && mem_wr && hit(mem_addr, mem_ext_access, data_off(3, 1'b1))
      && ({data_hi_reg[1], data_lo_reg[1]} == flash_iap_pkg::UNLOCK_PATTERN1)
      && ({data_hi_reg[2], data_lo_reg[2]} == flash_iap_pkg::UNLOCK_PATTERN2)
      && ({mem_wdata, data_lo_reg[3]} == flash_iap_pkg::UNLOCK_PATTERN3);
   assign cpu_hold = write_start_reg || read_start_reg;

   page_write_buffer u_buffer (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(buf_clear),
      .wr_en(buf_load),
      .wr_idx(addr_reg[5:0]),
      .wr_data({mem_wdata, data_lo_reg[0]}),
      .rd_idx(word_idx_reg),
      .rd_data(buf_word)
   );

   // ------------------------------------------------------------
   // process sequencer
   // ------------------------------------------------------------
   always_comb begin
      write_done = 1'b0;
      read_done = 1'b0;
      unique case (state_reg)
         flash_iap_pkg::ST_IDLE: begin
            // a start with the wrong mode or without enable ends at once
            write_done = write_start_reg && !(ew_enabled_reg
                         && (mode_reg == flash_iap_pkg::MODE_WRITE
                         || mode_reg == flash_iap_pkg::MODE_PAGE_ERASE));
            read_done = !write_start_reg && read_start_reg
                        && !(read_enable_reg && mode_reg == flash_iap_pkg::MODE_READ);
         end
         flash_iap_pkg::ST_ERASE: write_done = flash_ack;
         flash_iap_pkg::ST_PROG: write_done = prog_last;
         flash_iap_pkg::ST_READ: read_done = flash_ack;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= flash_iap_pkg::ST_IDLE;
         word_idx_reg <= 6'h00;
         flash_req <= 1'b0;
         flash_cmd <= 2'h0;
         flash_addr <= flash_iap_pkg::RESET_ADDRESS;
         flash_wdata <= flash_iap_pkg::RESET_WORD;
      end else begin
         unique case (state_reg)
            flash_iap_pkg::ST_IDLE: begin
               word_idx_reg <= 6'h00;
               if (write_start_reg && !write_done) begin
                  flash_req <= 1'b1;
                  if (mode_reg == flash_iap_pkg::MODE_PAGE_ERASE) begin
                     state_reg <= flash_iap_pkg::ST_ERASE;
                     flash_cmd <= flash_iap_pkg::CMD_ERASE;
                     flash_addr <= {addr_reg[13:6], 6'h00};
                  end else begin
                     state_reg <= flash_iap_pkg::ST_PROG;
                     flash_cmd <= flash_iap_pkg::CMD_PROGRAM;
                     flash_addr <= {addr_reg[13:6], 6'h00};
                     flash_wdata <= buf_word;
                  end
               end else if (!write_start_reg && read_start_reg && !read_done) begin
                  state_reg <= flash_iap_pkg::ST_READ;
                  flash_req <= 1'b1;
                  flash_cmd <= flash_iap_pkg::CMD_READ;
                  flash_addr <= addr_reg;
               end
            end
            flash_iap_pkg::ST_ERASE, flash_iap_pkg::ST_READ: begin
               if (flash_ack) begin
                  flash_req <= 1'b0;
                  state_reg <= flash_iap_pkg::ST_IDLE;
               end
            end
            flash_iap_pkg::ST_PROG: begin
               // one request per word, all 64 words of the page in turn
               if (flash_ack) begin
                  flash_req <= 1'b0;
                  if (prog_last) begin
                     state_reg <= flash_iap_pkg::ST_IDLE;
                  end else begin
                     word_idx_reg <= word_idx_reg + 6'h01;
                  end
               end else if (!flash_req) begin
                  flash_req <= 1'b1;
                  flash_addr <= {addr_reg[13:6], word_idx_reg};
                  flash_wdata <= buf_word;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // main control register
   // ------------------------------------------------------------
   // in every bit that hardware clears, a software set in the same cycle wins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ew_enabled_reg <= 1'b0;
         mode_reg <= 3'h0;
         trigger_reg <= 1'b0;
         write_start_reg <= 1'b0;
         read_enable_reg <= 1'b0;
         read_start_reg <= 1'b0;
      end else begin
         if (unlock_ok) begin
            ew_enabled_reg <= 1'b1;
         end else if (wr_main && !mem_wdata[flash_iap_pkg::BIT_ERASE_WRITE_ENABLED]) begin
            ew_enabled_reg <= 1'b0;
         end
         if (wr_main) begin
            mode_reg <= mem_wdata[flash_iap_pkg::BIT_MODE_LSB +: 3];
            read_enable_reg <= mem_wdata[flash_iap_pkg::BIT_READ_ENABLE];
         end
         if (wr_main) begin
            trigger_reg <= mem_wdata[flash_iap_pkg::BIT_ENABLE_TRIGGER];
         end else if (timeout) begin
            trigger_reg <= 1'b0;
         end
         if (wr_main && mem_wdata[flash_iap_pkg::BIT_WRITE_START]) begin
            write_start_reg <= 1'b1;
         end else if (write_done) begin
            write_start_reg <= 1'b0;
         end
         if (wr_main && mem_wdata[flash_iap_pkg::BIT_READ_START]) begin
            read_start_reg <= 1'b1;
         end else if (read_done) begin
            read_start_reg <= 1'b0;
         end
      end
   end

   // enable-procedure window timer, restarted by every trigger write
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_reg <= 12'h000;
      end else if (!trigger_reg || wr_main) begin
         timer_reg <= 12'h000;
      end else begin
         timer_reg <= timer_reg + 12'h001;
      end
   end

   // ------------------------------------------------------------
   // buffer clear, chip reset pattern, address and data registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         buffer_clear_reg <= 1'b0;
         reset_pattern_reg <= flash_iap_pkg::RESET_BYTE;
         chip_reset_req <= 1'b0;
      end else begin
         chip_reset_req <= 1'b0;
         if (mem_wr && hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_BUFFER_CLEAR)) begin
            buffer_clear_reg <= mem_wdata[flash_iap_pkg::BIT_BUFFER_CLEAR];
         end else if (buffer_clear_reg) begin
            buffer_clear_reg <= 1'b0;
         end
         if (mem_wr && hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_CHIP_RESET)) begin
            reset_pattern_reg <= mem_wdata;
            chip_reset_req <= (mem_wdata == flash_iap_pkg::CHIP_RESET_VALUE);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_reg <= flash_iap_pkg::RESET_ADDRESS;
      end else if (buf_load) begin
         if (addr_reg[5:0] != flash_iap_pkg::PAGE_LAST_WORD) begin
            addr_reg <= addr_reg + 14'h0001;
         end
      end else if (mem_wr && hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_ADDRESS_LOW)) begin
         addr_reg[7:0] <= mem_wdata;
      end else if (mem_wr && hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_ADDRESS_HIGH)) begin
         addr_reg[13:8] <= mem_wdata[5:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int n = 0; n < 4; n++) begin
            data_lo_reg[n] <= flash_iap_pkg::RESET_BYTE;
            data_hi_reg[n] <= flash_iap_pkg::RESET_BYTE;
         end
      end else begin
         for (int n = 0; n < 4; n++) begin
            if (mem_wr && hit(mem_addr, mem_ext_access, data_off(n, 1'b0))) begin
               data_lo_reg[n] <= mem_wdata;
            end
            if (mem_wr && hit(mem_addr, mem_ext_access, data_off(n, 1'b1))) begin
               data_hi_reg[n] <= mem_wdata;
            end
         end
         if (state_reg == flash_iap_pkg::ST_READ && flash_ack) begin
            data_lo_reg[0] <= flash_rdata[7:0];
            data_hi_reg[0] <= flash_rdata[15:8];
         end
      end
   end

   // ------------------------------------------------------------
   // read-back path, one cycle after the read strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_rdata <= flash_iap_pkg::RESET_BYTE;
      end else if (mem_rd) begin
         mem_rdata <= flash_iap_pkg::RESET_BYTE;
         if (hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_CONTROL_MAIN)) begin
            mem_rdata <= {ew_enabled_reg, mode_reg, trigger_reg, write_start_reg,
                          read_enable_reg, read_start_reg};
         end
         if (hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_CHIP_RESET)) begin
            mem_rdata <= reset_pattern_reg;
         end
         if (hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_BUFFER_CLEAR)) begin
            mem_rdata <= {7'h00, buffer_clear_reg};
         end
         if (hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_ADDRESS_LOW)) begin
            mem_rdata <= addr_reg[7:0];
         end
         if (hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_ADDRESS_HIGH)) begin
            mem_rdata <= {2'h0, addr_reg[13:8]};
         end
         for (int n = 0; n < 4; n++) begin
            if (hit(mem_addr, mem_ext_access, data_off(n, 1'b0))) begin
               mem_rdata <= data_lo_reg[n];
            end
            if (hit(mem_addr, mem_ext_access, data_off(n, 1'b1))) begin
               mem_rdata <= data_hi_reg[n];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_addr_inc;
      @(posedge clk) disable iff (sys_rst)
      buf_load && (addr_reg[5:0] != 6'h3F) |=> addr_reg == $past(addr_reg) + 14'h0001;
   endproperty
   a_addr_inc: assert property (p_addr_inc) else $error("address did not step");

   property p_addr_stop;
      @(posedge clk) disable iff (sys_rst)
      buf_load && (addr_reg[5:0] == 6'h3F) |=> $stable(addr_reg);
   endproperty
   a_addr_stop: assert property (p_addr_stop) else $error("address left the page");

   property p_no_load;
      @(posedge clk) disable iff (sys_rst)
      wr_high0 && !ew_enabled_reg |=> $stable(addr_reg);
   endproperty
   a_no_load: assert property (p_no_load) else $error("load while disabled");

   property p_fwt_fall;
      @(posedge clk) disable iff (sys_rst)
      $fell(write_start_reg) |-> $past(write_done) && $past(cpu_hold);
   endproperty
   a_fwt_fall: assert property (p_fwt_fall) else $error("write start dropped early");

   property p_read_gate;
      @(posedge clk) disable iff (sys_rst)
      read_start_reg && !write_start_reg && !read_enable_reg
      && state_reg == flash_iap_pkg::ST_IDLE
      |=> !read_start_reg && state_reg == flash_iap_pkg::ST_IDLE;
   endproperty
   a_read_gate: assert property (p_read_gate) else $error("read without enable");

   property p_buffer_clear;
      @(posedge clk) disable iff (sys_rst)
      buffer_clear_reg && !mem_wr |=> !buffer_clear_reg;
   endproperty
   a_buffer_clear: assert property (p_buffer_clear) else $error("buffer clear bit stuck");

   property p_erase_addr;
      @(posedge clk) disable iff (sys_rst)
      state_reg == flash_iap_pkg::ST_ERASE |-> flash_addr[5:0] == 6'h00
      && flash_addr[13:6] == addr_reg[13:6] && flash_cmd == 2'h1;
   endproperty
   a_erase_addr: assert property (p_erase_addr) else $error("bad erase page");

   property p_read_load;
      @(posedge clk) disable iff (sys_rst)
      state_reg == flash_iap_pkg::ST_READ && flash_ack
      |=> {data_hi_reg[0], data_lo_reg[0]} == $past(flash_rdata) && !read_start_reg;
   endproperty
   a_read_load: assert property (p_read_load) else $error("read word not loaded");

   property p_prog_clear;
      @(posedge clk) disable iff (sys_rst)
      prog_last |-> buf_clear ##1 (state_reg == flash_iap_pkg::ST_IDLE) && !write_start_reg;
   endproperty
   a_prog_clear: assert property (p_prog_clear) else $error("buffer kept after write");

   property p_high_zero;
      @(posedge clk) disable iff (sys_rst)
      mem_rd && hit(mem_addr, mem_ext_access, flash_iap_pkg::OFF_ADDRESS_HIGH)
      |=> mem_rdata[7:6] == 2'h0;
   endproperty
   a_high_zero: assert property (p_high_zero) else $error("high address top bits set");

   c_erase: cover property (@(posedge clk) disable iff (sys_rst)
      state_reg == flash_iap_pkg::ST_ERASE && flash_ack);
   c_program: cover property (@(posedge clk) disable iff (sys_rst) prog_last);
   c_read: cover property (@(posedge clk) disable iff (sys_rst)
      state_reg == flash_iap_pkg::ST_READ && flash_ack);
   c_unlock: cover property (@(posedge clk) disable iff (sys_rst) unlock_ok);

endmodule // flash_iap_controller

// *** flash_iap_controller_tb.sv ***
// self-checking bench for the flash programming controller
`timescale 1ns/1ps
module flash_iap_controller_tb;
   // ------------------------------------------------------------
   // stimulus, flash stand-in state and counters
   // ------------------------------------------------------------
   localparam logic [7:0] O_CTL = flash_iap_pkg::OFF_CONTROL_MAIN;
   localparam logic [7:0] O_CLR = flash_iap_pkg::OFF_BUFFER_CLEAR;
   localparam logic [7:0] O_AL = flash_iap_pkg::OFF_ADDRESS_LOW;
   localparam logic [7:0] O_AH = flash_iap_pkg::OFF_ADDRESS_HIGH;
   localparam logic [7:0] O_DL = flash_iap_pkg::OFF_DATA0_LOW;
   localparam logic [7:0] O_DH = O_DL + 8'h01;
   logic clk = 1'b0, sys_rst = 1'b1, mem_ext_access = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
   logic [9:0] mem_addr = 10'h000;
   logic [7:0] mem_wdata = 8'h00, mem_rdata, rv;
   logic cpu_hold, chip_reset_req, flash_req, flash_ack = 1'b0;
   logic [1:0] flash_cmd, last_cmd = 2'h0;
   logic [13:0] flash_addr, last_addr = 14'h0000;
   logic [15:0] flash_wdata, flash_rdata = 16'h0000;
   logic [15:0] pw [64];
   logic [15:0] pat [3];
   int req_count = 0, err_count = 0, checks = 0, cyc = 0, n0;

   flash_iap_controller u_dut (.clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr),
      .mem_ext_access(mem_ext_access), .mem_wr(mem_wr), .mem_rd(mem_rd),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .cpu_hold(cpu_hold),
      .chip_reset_req(chip_reset_req), .flash_req(flash_req), .flash_cmd(flash_cmd),
      .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_ack(flash_ack),
      .flash_rdata(flash_rdata));

   initial begin
      forever #2.5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // flash array stand-in: acks promptly, read data only valid at ack
   // ------------------------------------------------------------
   always @(negedge clk) begin
      flash_ack <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_req && !flash_ack) begin
         flash_ack <= 1'b1;
         last_cmd <= flash_cmd;
         last_addr <= flash_addr;
         req_count <= req_count + 1;
         flash_rdata <= {2'h0, flash_addr} ^ 16'hA000;
         if (flash_cmd == flash_iap_pkg::CMD_PROGRAM) pw[flash_addr[5:0]] <= flash_wdata;
      end
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // access, compare and closing tasks
   // ------------------------------------------------------------
   task automatic conclude();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one strobe per call; inputs move only at the falling edge
   task automatic acc(input logic [7:0] off, input logic [7:0] d, input logic w, input logic ext);
      @(negedge clk);
      mem_addr <= {flash_iap_pkg::REG_SECTOR, off};
      mem_wdata <= d;
      mem_wr <= w;
      mem_rd <= !w;
      mem_ext_access <= ext;
      @(negedge clk);
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      rv = mem_rdata;
   endtask

   task automatic rdc(input string nm, input logic [7:0] off, input logic [7:0] exp);
      acc(off, 8'h00, 1'b0, 1'b1);
      chk(nm, {8'h00, rv}, {8'h00, exp});
   endtask

   // the core may not touch registers while held, so wait on the hold line
   task automatic run(input logic [7:0] ctl);
      int n;
      n0 = req_count;
      acc(O_CTL, ctl, 1'b1, 1'b1);
      chk("hold_busy", {15'h0, cpu_hold}, 16'h0001);
      for (n = 0; n < 1000 && cpu_hold !== 1'b0; n++) @(negedge clk);
      chk("hold_release", {15'h0, cpu_hold}, 16'h0000);
   endtask

   task automatic word(input logic [15:0] d);
      acc(O_DL, d[7:0], 1'b1, 1'b1);
      acc(O_DH, d[15:8], 1'b1, 1'b1);
   endtask

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      pat = '{flash_iap_pkg::UNLOCK_PATTERN1, flash_iap_pkg::UNLOCK_PATTERN2,
         flash_iap_pkg::UNLOCK_PATTERN3};
      repeat (10) @(posedge clk);
      @(negedge clk);
      sys_rst <= 1'b0;
      rdc("addr_low_rst", O_AL, 8'h00);
      rdc("ctl_rst", O_CTL, 8'h00);
      acc(O_AH, 8'hFF, 1'b1, 1'b1);
      rdc("addr_high_top", O_AH, 8'h3F);
      acc(O_AL, 8'h11, 1'b1, 1'b0);
      rdc("addr_low_nonext", O_AL, 8'h00);
      word(16'h1234);
      rdc("addr_low_disabled", O_AL, 8'h00);
      acc(O_CTL, 8'h68, 1'b1, 1'b1);
      for (int i = 0; i < 3; i++) begin
         acc(O_DL + 8'(2 * i + 2), pat[i][7:0], 1'b1, 1'b1);
         acc(O_DL + 8'(2 * i + 3), pat[i][15:8], 1'b1, 1'b1);
      end
      rdc("ctl_enabled", O_CTL, 8'hE8);
      repeat (2100) @(negedge clk);
      rdc("trigger_timeout", O_CTL, 8'hE0);
      acc(O_AH, 8'h12, 1'b1, 1'b1);
      acc(O_AL, 8'h3E, 1'b1, 1'b1);
      word(16'h1234);
      rdc("addr_inc", O_AL, 8'h3F);
      word(16'hABCD);
      rdc("addr_stop", O_AL, 8'h3F);
      acc(O_AL, 8'h00, 1'b1, 1'b1); // back to word 0 of the same page after page end
      run(8'h94); // erase before write
      chk("erase_cmd", {14'h0, last_cmd}, {14'h0, flash_iap_pkg::CMD_ERASE});
      chk("erase_page", {2'h0, last_addr}, 16'h1200);
      rdc("erase_done", O_CTL, 8'h90);
      for (int i = 0; i < 64; i++) pw[i] = 16'hFFFF;
      run(8'h84);
      chk("prog_words", 16'(req_count - n0), 16'h0040);
      chk("prog_62", pw[62], 16'h1234);
      chk("prog_63", pw[63], 16'hABCD);
      chk("prog_0", pw[0], 16'h0000);
      rdc("write_done", O_CTL, 8'h80);
      run(8'h84);
      chk("auto_clear", pw[63], 16'h0000);
      acc(O_AL, 8'h00, 1'b1, 1'b1);
      word(16'h7777);
      acc(O_CLR, 8'h01, 1'b1, 1'b1); // clear after refill
      repeat (2) @(negedge clk);
      rdc("clear_done", O_CLR, 8'h00);
      run(8'h84);
      chk("clear_effect", pw[0], 16'h0000);
      acc(O_AL, 8'h05, 1'b1, 1'b1);
      acc(O_CTL, 8'hB2, 1'b1, 1'b1);
      run(8'hB3);
      chk("read_addr", {2'h0, last_addr}, 16'h1205);
      rdc("read_low", O_DL, 8'h05);
      rdc("read_high", O_DH, 8'hB2);
      acc(O_DL, 8'h99, 1'b1, 1'b1);
      rdc("low_only", O_DL, 8'h99);
      rdc("low_no_inc", O_AL, 8'h05);
      n0 = req_count;
      acc(O_CTL, 8'hB1, 1'b1, 1'b1);
      repeat (5) @(negedge clk);
      chk("read_refused", 16'(req_count - n0), 16'h0000);
      rdc("read_start_drop", O_CTL, 8'hB0);
      acc(O_CTL, 8'h04, 1'b1, 1'b1);
      repeat (5) @(negedge clk);
      chk("write_refused", 16'(req_count - n0), 16'h0000);
      rdc("write_start_drop", O_CTL, 8'h00);
      conclude();
   end
endmodule // flash_iap_controller_tb
